//--- verilog/rcfg_pkg.sv
// Constants, types and helpers for the receiver configuration block
// Functional notes
// - Burned nonvolatile configuration survives resets and reloads until erased or burned again
// - Bank written over the bus is lost at reset or power down
// - Crystal settle wait after power-up: 78..2480 us, default 310 us
// - Mode selects self-running or host-driven; host-driven is default
// - Sleep timer enable, default off
// - Sleep time 3..134152192 ms, used in self-running or with sleep timer
// - Receive timer enable, default off
// - Receive time 0.04..2683043 ms, default 1 ms, gated like sleep
// - Extended receive time, default 200 ms, only with wake-on-radio and timer
// - Receive early-exit enable, default off
// - Squelch threshold 8 bits, 0..255, default 0
// - Symbol rate in 0.1 ksps, max 40 OOK, 100 FSK, default 2.4; a rate written under FSK is not clamped when OOK is set later
// - Demodulation OOK or FSK, FSK default
// - Wake-on-radio enable, default off, gates extended receive time
// - After early exit go to idle hold or tune, idle hold default
package rcfg_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_CYC        = 1000 / CLK_PERIOD_NS;
  localparam int TICK_US       = 10;                    // Timer unit 0.01 ms
  localparam int TICK_CYC      = TICK_US * US_CYC;
  localparam int MS_TICKS      = 1000 / TICK_US;

  // ****************************************
  // Register map and commands
  // ****************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SLEEP  = 8'h04;
  localparam logic [7:0] A_RX     = 8'h08;
  localparam logic [7:0] A_RXEXT  = 8'h0c;
  localparam logic [7:0] A_SQL    = 8'h10;
  localparam logic [7:0] A_SYM    = 8'h14;
  localparam logic [7:0] A_CMD    = 8'h18;
  localparam logic [7:0] A_STAT   = 8'h1c;
  localparam int CMD_START = 0;
  localparam int CMD_IDLE  = 1;
  localparam int CMD_BURN  = 2;
  localparam logic [31:0] NVM_KEY = 32'h5a3c_0f96;      // Arbitrary marker value

  // ****************************************
  // Symbol rate limits, 0.1 ksps units
  // ****************************************
  localparam logic [9:0] SYM_MIN     = 10'h001;
  localparam logic [9:0] SYM_MAX_OOK = 10'h190;
  localparam logic [9:0] SYM_MAX_FSK = 10'h3e8;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        active;      // 1 self-running, 0 host-driven
    logic        sleep_en;
    logic        rx_en;
    logic        wor_en;
    logic        exit_en;
    logic        exit_tune;   // 1 tune, 0 idle hold
    logic        ook;         // 1 OOK, 0 FSK
    logic [2:0]  settle_sel;
    logic [26:0] sleep_ms;
    logic [28:0] rx_t;        // 0.01 ms units
    logic [28:0] rx_ext;
    logic [7:0]  squelch;
    logic [9:0]  sym_rate;
  } cfg_t;

  typedef struct packed {
    logic rx_on;
    logic sleep;
    logic tune;
    logic idle;
  } radio_t;

  typedef enum logic [5:0] {
    ST_SETTLE = 6'b000001,
    ST_IDLE   = 6'b000010,
    ST_SLEEP  = 6'b000100,
    ST_RX     = 6'b001000,
    ST_RXEXT  = 6'b010000,
    ST_TUNE   = 6'b100000
  } state_t;

  localparam cfg_t CFG_DEF = '{active: 1'b0, sleep_en: 1'b0, rx_en: 1'b0,
    wor_en: 1'b0, exit_en: 1'b0, exit_tune: 1'b0, ook: 1'b0,
    settle_sel: 3'h2, sleep_ms: 27'h00003e8, rx_t: 29'h00000064,
    rx_ext: 29'h00004e20, squelch: 8'h00, sym_rate: 10'h018};

  // Settle time in microseconds per selector
  function automatic logic [11:0] settle_us(input logic [2:0] sel);
    case (sel)
      3'h0:    settle_us = 12'h04e;
      3'h1:    settle_us = 12'h09b;
      3'h2:    settle_us = 12'h136;
      3'h3:    settle_us = 12'h26c;
      3'h4:    settle_us = 12'h4d8;
      default: settle_us = 12'h9b0;
    endcase
  endfunction : settle_us

endpackage : rcfg_pkg

//--- verilog/rcfg_core.sv
// Receiver configuration bank, nonvolatile image and duty timers
`timescale 1ns/10ps
module rcfg_core #(
  parameter int US_CYCLES   = rcfg_pkg::US_CYC,
  parameter int TICK_CYCLES = rcfg_pkg::TICK_CYC
) (
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic            nvm_erase,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic            sig_detect,
  input  wire logic            early_exit,
  output rcfg_pkg::radio_t     radio,
  output rcfg_pkg::cfg_t       cfg
);
  import rcfg_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  cfg_t        cfg_r, cfg_nxt, nvm_img_r;
  logic [31:0] nvm_key_r;
  state_t      state_r, state_nxt;
  radio_t      radio_r;
  logic [31:0] hrdata_r, rdata_w;
  logic        hready_r;
  logic        wr_pend_r;
  logic [7:0]  waddr_r;
  logic [1:0]  s1_r, s2_r;
  logic        s3_r;
  logic [33:0] tmr_r, tgt_w;
  logic [15:0] pre_r;
  logic        tick_w, done_w, nvm_ok, acc_w, early_w, det_w;
  logic        cmd_start, cmd_idle, burn_w, wr_cmd, rx_timed, sleep_timed;
  logic [9:0]  sym_cap;
  logic [2:0]  settle_sel_w;

  // Word decode of a bus address
  function automatic logic [7:0] word_of(input logic [31:0] a);
    word_of = {a[7:2], 2'b00};
  endfunction : word_of

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= {early_exit, sig_detect};
      s2_r <= s1_r;
      s3_r <= s2_r[1];
    end
  end

  assign det_w   = s2_r[0];
  assign early_w = cfg_r.exit_en && s2_r[1] && !s3_r;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Reads take one wait state so the data always comes from a flop
  assign acc_w  = hsel && htrans[1] && hready;
  assign wr_cmd = wr_pend_r && (waddr_r == A_CMD);
  assign cmd_start = wr_cmd && hwdata[CMD_START];
  assign cmd_idle  = wr_cmd && hwdata[CMD_IDLE];
  assign burn_w    = wr_cmd && hwdata[CMD_BURN];

  always_comb begin
    case (waddr_r)
      A_CTRL:  rdata_w = {21'h0, cfg_r.settle_sel, 1'b0, cfg_r.ook,
                          cfg_r.exit_tune, cfg_r.exit_en, cfg_r.wor_en,
                          cfg_r.rx_en, cfg_r.sleep_en, cfg_r.active};
      A_SLEEP: rdata_w = {5'h0, cfg_r.sleep_ms};
      A_RX:    rdata_w = {3'h0, cfg_r.rx_t};
      A_RXEXT: rdata_w = {3'h0, cfg_r.rx_ext};
      A_SQL:   rdata_w = {24'h0, cfg_r.squelch};
      A_SYM:   rdata_w = {22'h0, cfg_r.sym_rate};
      A_STAT:  rdata_w = {23'h0, nvm_ok, 2'h0, state_r};
      default: rdata_w = 32'h0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hready_r  <= 1'b1;
      hrdata_r  <= 32'h0;
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h0;
    end else begin
      wr_pend_r <= acc_w && hwrite;
      if (acc_w) begin
        waddr_r <= word_of(haddr);
      end
      if (acc_w && !hwrite) begin
        hready_r <= 1'b0;
      end else if (!hready_r) begin
        hready_r <= 1'b1;
        hrdata_r <= rdata_w;
      end
    end
  end

  // ****************************************
  // Configuration bank
  // ****************************************
  // Rate is clamped to the limit of the selected demodulation
  assign sym_cap = (hwdata[9:0] < SYM_MIN) ? SYM_MIN :
                   (cfg_r.ook && hwdata[9:0] > SYM_MAX_OOK) ? SYM_MAX_OOK :
                   (hwdata[9:0] > SYM_MAX_FSK) ? SYM_MAX_FSK : hwdata[9:0];

  always_comb begin
    cfg_nxt = cfg_r;
    if (state_r == ST_SETTLE) begin
      if (done_w && nvm_ok) begin
        cfg_nxt = nvm_img_r;
      end
    end else if (wr_pend_r) begin
      case (waddr_r)
        A_CTRL: begin
          cfg_nxt.active     = hwdata[0];
          cfg_nxt.sleep_en   = hwdata[1];
          cfg_nxt.rx_en      = hwdata[2];
          cfg_nxt.wor_en     = hwdata[3];
          cfg_nxt.exit_en    = hwdata[4];
          cfg_nxt.exit_tune  = hwdata[5];
          cfg_nxt.ook        = hwdata[6];
          cfg_nxt.settle_sel = hwdata[10:8];
        end
        A_SLEEP: cfg_nxt.sleep_ms = hwdata[26:0];
        A_RX:    cfg_nxt.rx_t     = hwdata[28:0];
        A_RXEXT: cfg_nxt.rx_ext   = hwdata[28:0];
        A_SQL:   cfg_nxt.squelch  = hwdata[7:0];
        A_SYM:   cfg_nxt.sym_rate = sym_cap;
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  // Bank returns to defaults on every reset; volatile by design
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= CFG_DEF;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************
  // Nonvolatile image
  // ****************************************
  // Not touched by sys_rst; only erase or a burn changes it
  assign nvm_ok = (nvm_key_r == NVM_KEY);

  always_ff @(posedge clock or posedge nvm_erase) begin
    if (nvm_erase) begin
      nvm_key_r <= 32'h0;
    end else if (burn_w) begin
      nvm_key_r <= NVM_KEY;
    end
  end

  always_ff @(posedge clock) begin
    if (burn_w) begin
      nvm_img_r <= cfg_r;
    end
  end

  // ****************************************
  // Duty timer
  // ****************************************
  assign rx_timed     = cfg_r.active || cfg_r.rx_en;
  assign sleep_timed  = cfg_r.active || cfg_r.sleep_en;
  assign settle_sel_w = nvm_ok ? nvm_img_r.settle_sel : CFG_DEF.settle_sel;
  assign tick_w = (state_r == ST_SETTLE) || (pre_r == 16'(TICK_CYCLES - 1));

  always_comb begin
    case (state_r)
      ST_SETTLE: tgt_w = 34'(settle_us(settle_sel_w) * US_CYCLES);
      ST_SLEEP:  tgt_w = 34'(cfg_r.sleep_ms) * 34'(MS_TICKS);
      ST_RX:     tgt_w = {5'h0, cfg_r.rx_t};
      ST_RXEXT:  tgt_w = {5'h0, cfg_r.rx_ext};
      default:   tgt_w = 34'h0;
    endcase
  end

  assign done_w = tick_w && (tmr_r + 34'h1 >= tgt_w);

  // Counter restarts on every state change
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_r <= 34'h0;
      pre_r <= 16'h0;
    end else if (state_nxt != state_r) begin
      tmr_r <= 34'h0;
      pre_r <= 16'h0;
    end else begin
      pre_r <= tick_w ? 16'h0 : pre_r + 16'h1;
      tmr_r <= tick_w ? tmr_r + 34'h1 : tmr_r;
    end
  end

  // ****************************************
  // Operating state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SETTLE: if (done_w) state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (cfg_r.active) state_nxt = ST_SLEEP;
        else if (cmd_start) state_nxt = ST_RX;
      end
      ST_SLEEP: begin
        if (cmd_idle && !cfg_r.active) state_nxt = ST_IDLE;
        else if (done_w) state_nxt = ST_RX;
      end
      ST_RX, ST_RXEXT: begin
        if (early_w) begin
          state_nxt = cfg_r.exit_tune ? ST_TUNE : ST_IDLE;
        end else if (cmd_idle) begin
          state_nxt = ST_IDLE;
        end else if (state_r == ST_RX && cfg_r.wor_en && cfg_r.rx_en && det_w) begin
          state_nxt = ST_RXEXT;
        end else if (rx_timed && done_w) begin
          state_nxt = sleep_timed ? ST_SLEEP : ST_IDLE;
        end
      end
      ST_TUNE: begin
        if (cmd_start || cfg_r.active) state_nxt = ST_RX;
        else if (cmd_idle) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_SETTLE;
      radio_r <= '0;
    end else begin
      state_r <= state_nxt;
      radio_r <= '{rx_on: state_nxt inside {ST_RX, ST_RXEXT},
                   sleep: state_nxt == ST_SLEEP, tune: state_nxt == ST_TUNE,
                   idle: state_nxt == ST_IDLE};
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hrdata    = hrdata_r;
  assign hreadyout = hready_r;
  assign hresp     = 1'b0;
  assign radio     = radio_r;
  assign cfg       = cfg_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [33:0] cyc_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cyc_r <= 34'h0;
    end else begin
      cyc_r <= (state_nxt != state_r) ? 34'h0 : cyc_r + 34'h1;
    end
  end

  sequence rd_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_SETTLE_LEN: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_SETTLE && state_nxt != ST_SETTLE) |-> (cyc_r + 34'h1 == tgt_w))
    else $error("settle wait length wrong");
  AST_DEFAULTS: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_SETTLE) |-> (cfg_r == CFG_DEF))
    else $error("bank not at defaults before settle end");
  AST_NVM_HOLD: assert property (@(posedge clock) disable iff (sys_rst || nvm_erase)
    (nvm_ok && !burn_w) |=> (nvm_img_r == $past(nvm_img_r)))
    else $error("stored image changed without burn");
  AST_NVM_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_SETTLE && done_w && nvm_ok) |=> (cfg_r == $past(nvm_img_r)))
    else $error("stored image not applied");
  AST_ACTIVE_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_SLEEP && done_w && !cmd_idle) |=> (state_r == ST_RX) ##0 radio.rx_on)
    else $error("sleep did not end in receive");
  AST_RX_UNTIMED: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_RX && !rx_timed && !cmd_idle && !early_w) |=> (state_r == ST_RX))
    else $error("receive timed out without timer");
  AST_EXT_GATE: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_RX && state_nxt == ST_RXEXT) |-> (cfg_r.wor_en && cfg_r.rx_en))
    else $error("extended receive without its enables");
  AST_EARLY_DEST: assert property (@(posedge clock) disable iff (sys_rst)
    (state_r == ST_RX && early_w) |=>
      (state_r == ($past(cfg_r.exit_tune) ? ST_TUNE : ST_IDLE)))
    else $error("early exit went to wrong state");
  AST_SYM_LIMIT: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(cfg_r.sym_rate) |-> (cfg_r.sym_rate >= SYM_MIN) &&
      (cfg_r.sym_rate <= (cfg_r.ook ? SYM_MAX_OOK : SYM_MAX_FSK)))
    else $error("symbol rate outside limit");
  AST_RD_WAIT: assert property (@(posedge clock) disable iff (sys_rst)
    (acc_w && !hwrite) |=> rd_wait_s)
    else $error("read wait state missing");

endmodule : rcfg_core

//--- verif/rcfg_host.sv
// AHB-Lite master model standing in for the external controller
`timescale 1ns/10ps
module rcfg_host (
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // ****************************************
  // Bus idle at time zero
  // ****************************************
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One single-word transfer; read data comes back in q
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    // Released data lines show no stale value
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : rcfg_host

//--- verif/receiver_config_and_duty_timers_tb.sv
// Self-checking bench for the receiver configuration and duty timers
`timescale 1ns/10ps
module receiver_config_and_duty_timers_tb;
  import rcfg_pkg::*;
  localparam logic [3:0] R_IDLE = 4'h1;
  localparam logic [3:0] R_TUNE = 4'h2;
  localparam logic [3:0] R_SLP  = 4'h4;
  localparam logic [3:0] R_RX   = 4'h8;
  logic        clock, sys_rst, nvm_erase, sig_detect, early_exit;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  radio_t      radio;
  cfg_t        cfg;
  int          mdl[8];
  int          img[8];
  int          srt[6] = '{0, 1000, 1023, 401, 5, 24};
  int          seed = 7;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;

  rcfg_host u_host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  rcfg_core #(.US_CYCLES(1), .TICK_CYCLES(4)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .nvm_erase(nvm_erase), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sig_detect(sig_detect),
    .early_exit(early_exit), .radio(radio), .cfg(cfg));

  // ****************************************
  // Clock, timeout and closing report
  // ****************************************
  initial clock = 1'b0;
  always #5 clock = ~clock;
  // Ceiling well above the few thousand cycles the scenarios need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task stop_test();
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ****************************************
  // Compare tasks and bank model
  // ****************************************
  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk_n(input string nm, input int lo, input int hi, input int v);
    compares++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : chk_n

  task mdef();
    mdl = '{32'h200, 1000, 100, 20000, 0, 24, 0, 0};
  endtask : mdef

  // Write through the host and mirror the documented field widths and clamp
  task mw(input int i, input int d);
    int m;
    u_host.xfer(1'b1, 32'(i * 4), 32'(d), q);
    m = mdl[0][6] ? 400 : 1000;
    case (i)
      0: mdl[0] = d & 'h77f;
      1: mdl[1] = d & 'h7ffffff;
      2, 3: mdl[i] = d & 'h1fffffff;
      4: mdl[4] = d & 'hff;
      5: mdl[5] = ((d & 'h3ff) < 1) ? 1 : ((d & 'h3ff) > m) ? m : (d & 'h3ff);
      default: ;
    endcase
  endtask : mw

  task mr(input int i);
    u_host.xfer(1'b0, 32'(i * 4), 32'h0, q);
    chk($sformatf("reg%0d", i), 128'(mdl[i]), 128'(q));
    chk("hresp", 128'h0, 128'(hresp));
  endtask : mr

  // Bounded wait for a duty state, sampled away from the clock edge
  task wt(input logic [3:0] s, output int k);
    k = 0;
    while (radio !== s && k < 3000) begin
      @(negedge clock);
      k++;
    end
    // A wait that runs out is a mismatch in its own right
    if (radio !== s) begin
      bad_count++;
      $display("unexpected radio expected %h seen %h", s, radio);
    end
  endtask : wt

  task rst(input int settle);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk("cfg_rst", 128'(CFG_DEF), 128'(cfg));
    chk("radio_rst", 128'h0, 128'(radio));
    @(posedge clock);
    sys_rst   <= 1'b0;
    nvm_erase <= 1'b0;
    wt(R_IDLE, n);
    chk_n("settle", settle - 3, settle + 4, n);
  endtask : rst

  task ex(input logic [3:0] s);
    @(posedge clock);
    early_exit <= 1'b1;
    wt(s, n);
    chk_n("exit", 1, 6, n);
    @(posedge clock);
    early_exit <= 1'b0;
  endtask : ex

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    nvm_erase = 1'b1;
    sig_detect = 1'b0;
    early_exit = 1'b0;
    mdef();
    rst(310);
    for (int i = 0; i < 6; i++) mr(i);
    u_host.xfer(1'b0, 32'h20, 32'h0, q);
    chk("unmapped", 128'h0, 128'(q));
    // Random squelch levels reach the bank and the radio settings
    repeat (4) begin
      mw(4, $random(seed));
      mr(4);
      chk("cfg_sql", 128'(mdl[4]), 128'(cfg.squelch));
    end
    for (int o = 0; o < 2; o++) begin
      mw(0, o << 6);
      // Bank flop updates at the edge the write ends; look once it has settled
      @(negedge clock);
      chk("cfg_ook", 128'(o), 128'(cfg.ook));
      foreach (srt[k]) begin
        mw(5, srt[k]);
        mr(5);
        chk("cfg_sym", 128'(mdl[5]), 128'(cfg.sym_rate));
      end
    end
    for (int i = 1; i < 4; i++) begin
      mw(i, $random(seed));
      mr(i);
    end
    // Short timers: 3 ms sleep is 1200 cycles, 4 ticks are 16 cycles
    mw(1, 3);
    mw(2, 4);
    mw(3, 8);
    mw(0, 'h4);
    mw(6, 1);
    wt(R_RX, n);
    wt(R_IDLE, n);
    chk_n("rx_len", 14, 19, n);
    mw(0, 'h6);
    mw(6, 1);
    wt(R_RX, n);
    wt(R_SLP, n);
    chk_n("rx_len", 14, 19, n);
    wt(R_RX, n);
    chk_n("sleep_len", 1196, 1204, n);
    mw(6, 2);
    wt(R_IDLE, n);
    chk_n("idle_cmd", 0, 8, n);
    // Detect during receive stretches it to the extended time
    mw(0, 'hc);
    mw(6, 1);
    wt(R_RX, n);
    @(posedge clock);
    sig_detect <= 1'b1;
    wt(R_IDLE, n);
    chk_n("rxext_len", 30, 44, n);
    @(posedge clock);
    sig_detect <= 1'b0;
    // Early exit to tune, to idle hold, and disabled
    mw(0, 'h30);
    mw(6, 1);
    wt(R_RX, n);
    repeat (40) @(negedge clock);
    chk("host_rx_held", 128'(R_RX), 128'(radio));
    ex(R_TUNE);
    mw(6, 2);
    wt(R_IDLE, n);
    mw(0, 'h10);
    mw(6, 1);
    wt(R_RX, n);
    ex(R_IDLE);
    mw(0, 0);
    mw(6, 1);
    wt(R_RX, n);
    @(posedge clock);
    early_exit <= 1'b1;
    repeat (10) @(negedge clock);
    chk("exit_off", 128'(R_RX), 128'(radio));
    @(posedge clock);
    early_exit <= 1'b0;
    mw(6, 2);
    wt(R_IDLE, n);
    // Self-running mode alternates sleep and receive
    mw(0, 1);
    wt(R_SLP, n);
    wt(R_RX, n);
    chk_n("act_sleep", 1196, 1204, n);
    wt(R_SLP, n);
    chk_n("act_rx", 14, 19, n);
    mw(0, 0);
    wt(R_RX, n);
    mw(6, 2);
    wt(R_IDLE, n);
    // Bank written on-line is lost at power down
    mw(4, 'h5a);
    rst(310);
    mdef();
    mr(4);
    // Burned image survives power down and is reapplied
    mw(0, 0);
    mw(4, 'h5a);
    mw(6, 4);
    img = mdl;
    u_host.xfer(1'b0, 32'h1c, 32'h0, q);
    chk("img_valid", 128'h1, 128'(q[8]));
    rst(78);
    mdl = img;
    for (int i = 0; i < 6; i++) mr(i);
    @(posedge clock);
    nvm_erase <= 1'b1;
    rst(310);
    mdef();
    mr(4);
    stop_test();
  end
endmodule : receiver_config_and_duty_timers_tb
